// *** shared/spt_pkg.sv ***
// Purpose: constants and types shared by the port link timer block
// Assumes: 50 MHz system clock, byte-addressed register port
// Notes: offsets are byte addresses
package spt_pkg;

	// register map
	localparam int ADDR_W = 20;
	localparam logic [19:0] TIMER_REG_OFS = 20'h12000;
	localparam logic [19:0] MODE_REG_OFS = 20'h12004;

	// timer settings register fields
	localparam int DISC_LSB = 28;
	localparam int RSND_LSB = 20;
	localparam logic [3:0] DISC_RST = 4'h9;
	localparam logic [3:0] RSND_RST = 4'h8;
	localparam logic [3:0] DISC_MIN_CODE = 4'h1;

	// mode register fields
	localparam int LANE_CFG_LSB = 30;
	localparam int IDLE_CHK_OFF_BIT = 29;
	localparam int TXFIFO_BYP_BIT = 28;
	localparam int MSG_OFF_BIT = 27;
	localparam int SELF_RST_BIT = 25;
	localparam int MC_IRQ_EN_BIT = 5;
	localparam int MC_FLAG_BIT = 4;
	localparam int RST_EN_BIT = 3;
	localparam int RST_CS_BIT = 2;
	localparam int ER_IRQ_EN_BIT = 1;
	localparam int ER_FLAG_BIT = 0;
	localparam logic [1:0] LANE_CFG_RST = 2'h0;

	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int DISC_UNIT_NS = 840000;
	localparam int RSND_UNIT_NS = 107000000;
	localparam int DISC_UNIT_CYC = DISC_UNIT_NS / CLK_PERIOD_NS;
	localparam int RSND_UNIT_CYC = RSND_UNIT_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		SPT_D_IDLE = 2'h0,
		SPT_D_WAIT = 2'h1,
		SPT_D_DONE = 2'h3
	} spt_disc_st_t;

	typedef enum logic [1:0] {
		SPT_R_IDLE = 2'h0,
		SPT_R_REPEAT = 2'h1,
		SPT_R_HELD = 2'h3
	} spt_rsnd_st_t;

	typedef struct packed {
		logic [1:0] port_lane_config;
		logic idle_symbol_check_off;
		logic tx_fifo_bypass;
		logic error_report_msg_off;
		logic self_reset_en;
		logic multicast_event_irq_enable;
		logic multicast_event_flag;
		logic reset_irq_en;
		logic reset_irq_cs;
		logic error_report_irq_enable;
		logic error_report_flag;
	} spt_mode_t;

	typedef struct packed {
		logic [19:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} spt_bus_req_t;

	typedef struct packed {
		logic [3:0] disc_code;
		logic [3:0] error_report_resend_period;
		spt_mode_t mode;
		spt_disc_st_t disc_st;
		logic [3:0] disc_cnt;
		logic disc_timeout;
		spt_rsnd_st_t rsnd_st;
		logic [4:0] rsnd_cnt;
		logic pw_req;
		logic [31:0] rdata;
	} spt_state_t;

endpackage

// *** verilog/spt_tick_gen.sv ***
// Purpose: free-running prescaler giving a one-cycle tick
// Assumes: PERIOD_CYC of at least 2
// Notes: tick phase is not tied to any request
`timescale 1ns/1ps
module spt_tick_gen #(
	parameter int unsigned PERIOD_CYC = 42000
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// tick out
	output logic tick
);
	localparam int W = $clog2(PERIOD_CYC);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} spt_tick_state_t;

	spt_tick_state_t st_ff;
	spt_tick_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (st_ff.cnt == W'(PERIOD_CYC - 1)) begin
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;
endmodule

// *** verilog/spt_link_timers.sv ***
// Purpose: discovery timer and error-report resend timer of a serial port
// Assumes: control inputs come from port logic on clk
// Notes: both timers count free-running prescaler ticks
//
// Behaviour
// - discovery waits the programmed discovery period
// - discovery period is code times 0.84 ms
// - discovery code resets to nine
// - pending error resends report periodically
// - error detect write stops the resends
// - resend code zero sends only once
// - resend period follows code, default 1000b
// - reserved timer bits read zero
// - message-off bit suppresses all reports
`timescale 1ns/1ps
module spt_link_timers #(
	parameter int unsigned DISC_UNIT_CYC = spt_pkg::DISC_UNIT_CYC,
	parameter int unsigned RSND_UNIT_CYC = spt_pkg::RSND_UNIT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire spt_pkg::spt_bus_req_t reg_req,
	output logic [31:0] reg_rdata,
	// link discovery
	input wire logic disc_start,
	output logic disc_timeout,
	// error reporting
	input wire logic err_pending,
	input wire logic err_detect_wr,
	output logic pw_req,
	// mode controls to the port
	output spt_pkg::spt_mode_t mode_ctl
);
	spt_pkg::spt_state_t st_ff;
	spt_pkg::spt_state_t nxt_st;
	logic disc_tick;
	logic rsnd_tick;

	spt_tick_gen #(
		.PERIOD_CYC(DISC_UNIT_CYC)
	) u_disc_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(disc_tick)
	);

	spt_tick_gen #(
		.PERIOD_CYC(RSND_UNIT_CYC)
	) u_rsnd_tick (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(rsnd_tick)
	);

	function automatic logic [31:0] mode_word(input spt_pkg::spt_mode_t m);
		logic [31:0] w;
		w = 32'h0;
		w[spt_pkg::LANE_CFG_LSB +: 2] = m.port_lane_config;
		w[spt_pkg::IDLE_CHK_OFF_BIT] = m.idle_symbol_check_off;
		w[spt_pkg::TXFIFO_BYP_BIT] = m.tx_fifo_bypass;
		w[spt_pkg::MSG_OFF_BIT] = m.error_report_msg_off;
		w[spt_pkg::SELF_RST_BIT] = m.self_reset_en;
		w[spt_pkg::MC_IRQ_EN_BIT] = m.multicast_event_irq_enable;
		w[spt_pkg::MC_FLAG_BIT] = m.multicast_event_flag;
		w[spt_pkg::RST_EN_BIT] = m.reset_irq_en;
		w[spt_pkg::RST_CS_BIT] = m.reset_irq_cs;
		w[spt_pkg::ER_IRQ_EN_BIT] = m.error_report_irq_enable;
		w[spt_pkg::ER_FLAG_BIT] = m.error_report_flag;
		return w;
	endfunction

	always_comb begin
		logic [3:0] disc_lim;
		logic [3:0] disc_inc;
		logic fire;
		logic [31:0] tw;
		disc_lim = 4'h0;
		disc_inc = 4'h0;
		fire = 1'b0;
		tw = 32'h0;
		nxt_st = st_ff;
		nxt_st.disc_timeout = 1'b0;
		nxt_st.pw_req = 1'b0;
		nxt_st.rdata = 32'h0;

		// register writes
		if (reg_req.wr) begin
			if (reg_req.addr == spt_pkg::TIMER_REG_OFS) begin
				nxt_st.disc_code = reg_req.wdata[spt_pkg::DISC_LSB +: 4];
				nxt_st.error_report_resend_period = reg_req.wdata[spt_pkg::RSND_LSB +: 4];
			end else if (reg_req.addr == spt_pkg::MODE_REG_OFS) begin
				nxt_st.mode.port_lane_config = reg_req.wdata[spt_pkg::LANE_CFG_LSB +: 2];
				nxt_st.mode.idle_symbol_check_off = reg_req.wdata[spt_pkg::IDLE_CHK_OFF_BIT];
				nxt_st.mode.tx_fifo_bypass = reg_req.wdata[spt_pkg::TXFIFO_BYP_BIT];
				nxt_st.mode.error_report_msg_off = reg_req.wdata[spt_pkg::MSG_OFF_BIT];
				nxt_st.mode.self_reset_en = reg_req.wdata[spt_pkg::SELF_RST_BIT];
				nxt_st.mode.multicast_event_irq_enable = reg_req.wdata[spt_pkg::MC_IRQ_EN_BIT];
				nxt_st.mode.multicast_event_flag = reg_req.wdata[spt_pkg::MC_FLAG_BIT];
				nxt_st.mode.reset_irq_en = reg_req.wdata[spt_pkg::RST_EN_BIT];
				nxt_st.mode.reset_irq_cs = reg_req.wdata[spt_pkg::RST_CS_BIT];
				nxt_st.mode.error_report_irq_enable = reg_req.wdata[spt_pkg::ER_IRQ_EN_BIT];
				nxt_st.mode.error_report_flag = reg_req.wdata[spt_pkg::ER_FLAG_BIT];
			end
		end

		// register reads, data valid in the next cycle only
		if (reg_req.rd) begin
			if (reg_req.addr == spt_pkg::TIMER_REG_OFS) begin
				tw[spt_pkg::DISC_LSB +: 4] = st_ff.disc_code;
				tw[spt_pkg::RSND_LSB +: 4] = st_ff.error_report_resend_period;
				nxt_st.rdata = tw;
			end else if (reg_req.addr == spt_pkg::MODE_REG_OFS) begin
				nxt_st.rdata = mode_word(st_ff.mode);
			end
		end

		// discovery timer; reserved code 0 runs as code 1
		disc_lim = (st_ff.disc_code == 4'h0) ? spt_pkg::DISC_MIN_CODE : st_ff.disc_code;
		disc_inc = st_ff.disc_cnt + 4'h1;
		unique case (st_ff.disc_st)
			spt_pkg::SPT_D_IDLE, spt_pkg::SPT_D_DONE: begin
				if (disc_start) begin
					nxt_st.disc_st = spt_pkg::SPT_D_WAIT;
					nxt_st.disc_cnt = 4'h0;
				end
			end
			spt_pkg::SPT_D_WAIT: begin
				if (disc_start) begin
					nxt_st.disc_cnt = 4'h0;
				end else if (disc_tick) begin
					nxt_st.disc_cnt = disc_inc;
					if (disc_inc >= disc_lim) begin
						nxt_st.disc_timeout = 1'b1;
						nxt_st.disc_st = spt_pkg::SPT_D_DONE;
					end
				end
			end
			default: begin
				nxt_st.disc_st = spt_pkg::SPT_D_IDLE;
			end
		endcase

		// resend timer: code+1 free ticks give code..code+1 units
		unique case (st_ff.rsnd_st)
			spt_pkg::SPT_R_IDLE: begin
				if (err_pending && !err_detect_wr) begin
					fire = 1'b1;
					nxt_st.rsnd_cnt = 5'h0;
					if (st_ff.error_report_resend_period == 4'h0) begin
						nxt_st.rsnd_st = spt_pkg::SPT_R_HELD;
					end else begin
						nxt_st.rsnd_st = spt_pkg::SPT_R_REPEAT;
					end
				end else if (err_pending) begin
					// detect write beside a new error: nothing is sent
					nxt_st.rsnd_st = spt_pkg::SPT_R_HELD;
				end
			end
			spt_pkg::SPT_R_REPEAT: begin
				if (!err_pending) begin
					nxt_st.rsnd_st = spt_pkg::SPT_R_IDLE;
				end else if (err_detect_wr) begin
					nxt_st.rsnd_st = spt_pkg::SPT_R_HELD;
				end else if (st_ff.error_report_resend_period == 4'h0) begin
					nxt_st.rsnd_st = spt_pkg::SPT_R_HELD;
				end else if (rsnd_tick) begin
					if (st_ff.rsnd_cnt >= {1'b0, st_ff.error_report_resend_period}) begin
						fire = 1'b1;
						nxt_st.rsnd_cnt = 5'h0;
					end else begin
						nxt_st.rsnd_cnt = st_ff.rsnd_cnt + 5'h1;
					end
				end
			end
			spt_pkg::SPT_R_HELD: begin
				if (!err_pending) begin
					nxt_st.rsnd_st = spt_pkg::SPT_R_IDLE;
				end
			end
			default: begin
				nxt_st.rsnd_st = spt_pkg::SPT_R_IDLE;
			end
		endcase

		if (fire && !st_ff.mode.error_report_msg_off) begin
			nxt_st.pw_req = 1'b1;
			nxt_st.mode.error_report_flag = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.disc_code <= spt_pkg::DISC_RST;
			st_ff.error_report_resend_period <= spt_pkg::RSND_RST;
			st_ff.mode.port_lane_config <= spt_pkg::LANE_CFG_RST;
			st_ff.disc_st <= spt_pkg::SPT_D_IDLE;
			st_ff.rsnd_st <= spt_pkg::SPT_R_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign disc_timeout = st_ff.disc_timeout;
	assign pw_req = st_ff.pw_req;
	assign mode_ctl = st_ff.mode;
endmodule

// *** tb/spt_link_timers_chk.sv ***
// Purpose: port-level checks for the link timer block
// Assumes: timer code tracked from register writes
// Notes: bound to spt_link_timers
`timescale 1ns/1ps
module spt_link_timers_chk #(
	parameter int unsigned DISC_UNIT_CYC = 8,
	parameter int unsigned RSND_UNIT_CYC = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire spt_pkg::spt_bus_req_t reg_req,
	input wire logic [31:0] reg_rdata,
	// timers
	input wire logic disc_start,
	input wire logic disc_timeout,
	input wire logic err_pending,
	input wire logic err_detect_wr,
	input wire logic pw_req,
	input wire spt_pkg::spt_mode_t mode_ctl
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [3:0] dc_ff;
	logic [3:0] rc_ff;
	int dn_ff;
	int gp_ff;
	logic st_ff;
	logic pv_ff;
	int nd;
	assign nd = (dc_ff == 4'h0) ? 1 : int'(dc_ff);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dc_ff <= 4'h9;
			rc_ff <= 4'h8;
			dn_ff <= 0;
			gp_ff <= 0;
			st_ff <= 1'b0;
			pv_ff <= 1'b0;
		end else begin
			if (reg_req.wr && reg_req.addr == spt_pkg::TIMER_REG_OFS) begin
				dc_ff <= reg_req.wdata[31:28];
				rc_ff <= reg_req.wdata[23:20];
			end
			dn_ff <= disc_start ? 1 : dn_ff + 1;
			gp_ff <= pw_req ? 1 : gp_ff + 1;
			st_ff <= err_pending && (st_ff || err_detect_wr);
			pv_ff <= err_pending && (pv_ff || pw_req);
		end
	end
	a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside read");
	a_resv_zero: assert property (reg_req.rd && reg_req.addr == spt_pkg::TIMER_REG_OFS
		|=> (reg_rdata & 32'h0F0FFFFF) == 32'h0)
		else $error("reserved timer bits not zero");
	a_disc_window: assert property (disc_timeout |-> dn_ff > (nd - 1) * DISC_UNIT_CYC
		&& dn_ff <= nd * DISC_UNIT_CYC + 1)
		else $error("discovery period out of range");
	a_disc_pulse: assert property (disc_timeout |=> !disc_timeout)
		else $error("discovery timeout longer than one cycle");
	a_pw_first: assert property ($rose(err_pending) && !err_detect_wr
		&& !mode_ctl.error_report_msg_off |=> pw_req)
		else $error("no report on new error");
	a_pw_gap: assert property (pw_req && pv_ff |-> rc_ff != 4'h0 && gp_ff >= rc_ff * RSND_UNIT_CYC
		&& gp_ff <= (rc_ff + 1) * RSND_UNIT_CYC + 1)
		else $error("report repeat period wrong");
	a_stop_hold: assert property (st_ff && $past(st_ff) |-> !pw_req)
		else $error("report repeated after stop");
	a_msg_off: assert property (mode_ctl.error_report_msg_off
		&& $past(mode_ctl.error_report_msg_off) |-> !pw_req)
		else $error("report sent while disabled");
endmodule
bind spt_link_timers spt_link_timers_chk #(.DISC_UNIT_CYC(DISC_UNIT_CYC), .RSND_UNIT_CYC(RSND_UNIT_CYC)) i_chk (
	.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .disc_start(disc_start),
	.disc_timeout(disc_timeout), .err_pending(err_pending), .err_detect_wr(err_detect_wr),
	.pw_req(pw_req), .mode_ctl(mode_ctl));

// *** tb/spt_link_partner.sv ***
// Purpose: far-end model counting received port-writes
// Assumes: pw_req is a one-cycle pulse
// Notes: each pulse is one request on the link
`timescale 1ns/1ps
module spt_link_partner (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// requests from the port
	input wire logic pw_req,
	// received count
	output int n_pw
);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			n_pw <= 0;
		end else if (pw_req === 1'b1) begin
			n_pw <= n_pw + 1;
		end
	end
endmodule

// *** tb/tb_top.sv ***
// Purpose: register and timer tests of the link timer block
// Assumes: short units, 8 and 16 cycles
// Notes: pulse counts come from the partner
`timescale 1ns/1ps
module tb_top;
	localparam int DU = 8;
	localparam int RU = 16;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic disc_start = 1'b0;
	logic err_pending = 1'b0;
	logic err_detect_wr = 1'b0;
	spt_pkg::spt_bus_req_t req = '0;
	spt_pkg::spt_mode_t mode_ctl;
	logic [31:0] reg_rdata;
	logic disc_timeout;
	logic pw_req;
	int n_pw;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;
	int lo;
	int hi;
	logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
	spt_link_timers #(.DISC_UNIT_CYC(DU), .RSND_UNIT_CYC(RU)) i_spt_link_timers (.clk(clk), .sys_rst(sys_rst),
		.reg_req(req), .reg_rdata(reg_rdata), .disc_start(disc_start), .disc_timeout(disc_timeout),
		.err_pending(err_pending), .err_detect_wr(err_detect_wr), .pw_req(pw_req), .mode_ctl(mode_ctl));
	spt_link_partner i_spt_link_partner (.clk(clk), .sys_rst(sys_rst), .pw_req(pw_req), .n_pw(n_pw));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, input logic [31:0] e);
		@(posedge clk);
		req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, reg_rdata);
	endtask
	task automatic disc(input int c);
		@(posedge clk);
		disc_start <= 1'b1;
		@(posedge clk);
		disc_start <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (disc_timeout !== 1'b1 && n < 200);
		chk("disc_delay", 1, n > (c - 1) * DU && n <= c * DU + 1);
		@(negedge clk);
		chk("disc_pulse", 0, disc_timeout);
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(spt_pkg::TIMER_REG_OFS, 32'h90800000);
		rd(spt_pkg::MODE_REG_OFS, 32'h0);
		rd(20'h12008, 32'h0);
		disc(9);
		wr(spt_pkg::TIMER_REG_OFS, 32'hFFFFFFFF);
		rd(spt_pkg::TIMER_REG_OFS, 32'hF0F00000);
		disc(15);
		wr(spt_pkg::TIMER_REG_OFS, 32'h10000000);
		disc(1);
		wr(spt_pkg::TIMER_REG_OFS, 32'h00000000);
		disc(1);
		foreach (codes[i]) begin
			wr(spt_pkg::TIMER_REG_OFS, {8'h10, codes[i], 20'h0});
			n = n_pw;
			err_pending <= 1'b1;
			repeat (300) @(posedge clk);
			err_pending <= 1'b0;
			repeat (2) @(posedge clk);
			lo = codes[i] == 4'h0 ? 0 : 290 / ((codes[i] + 1) * RU + 1);
			hi = codes[i] == 4'h0 ? 0 : 301 / (codes[i] * RU);
			chk("pw_count", 1, n_pw - n - 1 >= lo && n_pw - n - 1 <= hi);
		end
		wr(spt_pkg::TIMER_REG_OFS, 32'h10100000);
		err_pending <= 1'b1;
		repeat (40) @(posedge clk);
		err_detect_wr <= 1'b1;
		@(posedge clk);
		err_detect_wr <= 1'b0;
		repeat (3) @(negedge clk);
		n = n_pw;
		repeat (100) @(posedge clk);
		err_pending <= 1'b0;
		@(negedge clk);
		chk("pw_stop", n, n_pw);
		wr(spt_pkg::MODE_REG_OFS, 32'hFFFFFFFF);
		rd(spt_pkg::MODE_REG_OFS, 32'hFA00003F);
		chk("msg_off", 1, mode_ctl.error_report_msg_off);
		n = n_pw;
		@(posedge clk);
		err_pending <= 1'b1;
		repeat (60) @(posedge clk);
		err_pending <= 1'b0;
		repeat (2) @(negedge clk);
		chk("pw_off", n, n_pw);
		end_of_test();
	end
endmodule
